// [design/oprc_pkg.sv]
// Purpose: constants and types for the dual-role port role control register
// Assumes: 32-bit word view of the processor bus, byte enables per lane
// Notes: set half sits in lanes 1:0, clear half in lanes 3:2
package oprc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] OPRC_ADDR_SET = 16'h0374;
  localparam logic [15:0] OPRC_ADDR_CLR = 16'h0376;
  localparam int OPRC_CTRL_W = 11;
  localparam logic [10:0] OPRC_CTRL_RST = 11'h086;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OPRC_B_PULLUP = 0;
  localparam int OPRC_B_DP_PD = 1;
  localparam int OPRC_B_DM_PD = 2;
  localparam int OPRC_B_EXT_PUMP = 3;
  localparam int OPRC_B_DRIVE = 4;
  localparam int OPRC_B_DISCH = 5;
  localparam int OPRC_B_PRECH = 6;
  localparam int OPRC_B_SELECT = 7;
  localparam int OPRC_B_AUTO_RECON = 8;
  localparam int OPRC_B_RST_CONN = 9;
  localparam int OPRC_B_NEG_OFF = 10;
  // ------------------------------------------------------------
  // decoded control carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic negotiation_off;
    logic reset_on_connect_en;
    logic auto_reconnect_en;
    logic controller_select;
    logic bus_power_precharge;
    logic bus_power_discharge;
    logic bus_power_drive;
    logic external_pump_select;
    logic minus_line_pulldown;
    logic plus_line_pulldown;
    logic plus_line_pullup;
  } oprc_ctrl_type;
endpackage

// [design/oprc_role_ctrl.sv]
// Purpose: role control register of a dual-role port with set/clear halves
// Assumes: one clock, pin events are asynchronous and get synchronised here
// Notes: all outputs are flip-flops, one cycle behind the register
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - bits 15..11 hold nothing and always read as zero.
// - bit 10 zero enables negotiation; one makes port pure host or peripheral.
// - bit 9 set makes host send bus reset when a remote connect appears.
// - bit 8 set lets the A side connect after B disconnect.
// - bit 7 zero attaches host controller, one attaches peripheral controller.
// - disconnect-then-connect event forces bit 7 to one in hardware.
// - with bit 8 set, remote disconnect connects the pull-up automatically.
// - bit 5 discharges bus power to ground through a resistor.
// - bit 4 enables the charge pump driving bus power to five volts.
// - bit 3 zero picks on-chip pump, one picks external pump.
// - bit 2 enables the minus line pull-down.
// - bit 1 enables the plus line pull-down.
// - writing one to set half sets, to clear half clears; zero keeps.
// - with negotiation off, bit 7 alone picks host or peripheral.
module oprc_role_ctrl (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [3:0] bus_be_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  input wire logic disconnect_then_connect_event_i,
  input wire logic remote_disconnect_i,
  input wire logic remote_connect_i,
  output logic negotiation_active_o,
  output logic peripheral_attached_o,
  output logic host_attached_o,
  output logic bus_reset_req_o,
  output logic a_connect_allow_o,
  output logic bus_power_precharge_o,
  output logic bus_power_discharge_o,
  output logic internal_pump_en_o,
  output logic external_pump_en_o,
  output logic minus_line_pulldown_o,
  output logic plus_line_pulldown_o,
  output logic plus_line_pullup_o
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic dtc_rise;
  logic rdis_rise;
  logic rcon_rise;

  // two flops against metastability, a third remembers the last level
  oprc_sync_edge u_dtc_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(disconnect_then_connect_event_i),
    .rise_o(dtc_rise)
  );

  oprc_sync_edge u_rdis_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(remote_disconnect_i),
    .rise_o(rdis_rise)
  );

  oprc_sync_edge u_rcon_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(remote_connect_i),
    .rise_o(rcon_rise)
  );

  // the carrier and the stored word must agree in width
  if ($bits(oprc_pkg::oprc_ctrl_type) != oprc_pkg::OPRC_CTRL_W) begin : g_width_check
    $error("control carrier width mismatch");
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic [10:0] ctrl_q;
  logic [10:0] ctrl_d;
  wire word_hit = bus_cs_i & (bus_addr_i[15:2] == oprc_pkg::OPRC_ADDR_SET[15:2]);
  wire wr_hit = word_hit & bus_wr_i;
  // set half in lanes 1:0, clear half in lanes 3:2
  wire [15:0] set_mask = {bus_wdata_i[15:8] & {8{bus_be_i[1] & wr_hit}},
                          bus_wdata_i[7:0] & {8{bus_be_i[0] & wr_hit}}};
  wire [15:0] clr_mask = {bus_wdata_i[31:24] & {8{bus_be_i[3] & wr_hit}},
                          bus_wdata_i[23:16] & {8{bus_be_i[2] & wr_hit}}};
  // the hardware event may only set the select bit
  wire [10:0] hw_set = {3'h0, dtc_rise, 7'h00};
  // set beats clear, so a hardware or software set is never lost
  always_comb begin
    ctrl_d = (ctrl_q & ~clr_mask[10:0]) | set_mask[10:0] | hw_set;
  end
  wire [15:0] ctrl_view = {5'h00, ctrl_q};

  oprc_pkg::oprc_ctrl_type ctrl;
  assign ctrl = oprc_pkg::oprc_ctrl_type'(ctrl_q);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= oprc_pkg::OPRC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  wire [31:0] rdata_d = (word_hit & ~bus_wr_i) ? {ctrl_view, ctrl_view} : 32'h0000_0000;

  // ------------------------------------------------------------
  // automatic pull-up on remote disconnect
  // ------------------------------------------------------------
  logic auto_pullup_q;
  wire auto_pullup_d = ctrl.auto_reconnect_en & (auto_pullup_q | rdis_rise);

  // ------------------------------------------------------------
  // pin controls
  // ------------------------------------------------------------
  wire host_sel = ~ctrl.controller_select;
  wire reset_req_d = ctrl.reset_on_connect_en & host_sel & rcon_rise;

  // ------------------------------------------------------------
  // output next values
  // ------------------------------------------------------------
  wire neg_active_d = ~ctrl.negotiation_off;
  wire int_pump_d = ctrl.bus_power_drive & ~ctrl.external_pump_select;
  wire ext_pump_d = ctrl.bus_power_drive & ctrl.external_pump_select;
  wire pullup_d = ctrl.plus_line_pullup | auto_pullup_q;

  // ------------------------------------------------------------
  // latch and read data flops
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_pullup_q <= 1'b0;
    end else begin
      auto_pullup_q <= auto_pullup_d;
    end
  end

  // a read answer stands for exactly one cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= 32'h0000_0000;
    end else begin
      bus_rdata_o <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // role outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      negotiation_active_o <= 1'b0;
    end else begin
      negotiation_active_o <= neg_active_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peripheral_attached_o <= 1'b0;
    end else begin
      peripheral_attached_o <= ctrl.controller_select;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_attached_o <= 1'b0;
    end else begin
      host_attached_o <= host_sel;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_reset_req_o <= 1'b0;
    end else begin
      bus_reset_req_o <= reset_req_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_connect_allow_o <= 1'b0;
    end else begin
      a_connect_allow_o <= ctrl.auto_reconnect_en;
    end
  end

  // ------------------------------------------------------------
  // bus power outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_power_precharge_o <= 1'b0;
    end else begin
      bus_power_precharge_o <= ctrl.bus_power_precharge;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_power_discharge_o <= 1'b0;
    end else begin
      bus_power_discharge_o <= ctrl.bus_power_discharge;
    end
  end

  // only one pump may ever run
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      internal_pump_en_o <= 1'b0;
    end else begin
      internal_pump_en_o <= int_pump_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      external_pump_en_o <= 1'b0;
    end else begin
      external_pump_en_o <= ext_pump_d;
    end
  end

  // ------------------------------------------------------------
  // line resistor outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      minus_line_pulldown_o <= 1'b0;
    end else begin
      minus_line_pulldown_o <= ctrl.minus_line_pulldown;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      plus_line_pulldown_o <= 1'b0;
    end else begin
      plus_line_pulldown_o <= ctrl.plus_line_pulldown;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      plus_line_pullup_o <= 1'b0;
    end else begin
      plus_line_pullup_o <= pullup_d;
    end
  end

endmodule

// ------------------------------------------------------------
// pin synchroniser with rising edge detect
// ------------------------------------------------------------
module oprc_sync_edge #(
  parameter int STAGES = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o
);

  // fewer than two flops would let a metastable level into the logic
  if (STAGES < 2) begin : g_stage_check
    $error("oprc_sync_edge needs at least two stages");
  end

  logic [STAGES:0] chain_q;

  // the history flop resets low, matching the idle level of the pins
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-1:0], pin_i};
    end
  end

  // only the last synchroniser flop and the history flop feed the edge
  assign rise_o = chain_q[STAGES-1] & ~chain_q[STAGES];

endmodule
`default_nettype wire

// [test/oprc_sw_model.sv]
// Purpose: processor bus master for the role control register
// Assumes: one access at a time, launched on rising edges
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module oprc_sw_model (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  output logic cs_o,
  output logic wr_o,
  output logic [15:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  initial {cs_o, wr_o, addr_o, be_o, wdata_o} = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_i);
    {cs_o, wr_o, addr_o, be_o, wdata_o} <= {1'b1, w, a, b, d};
    @(posedge clock_i);
    {cs_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
    #1 r = rdata_i;
  endtask
endmodule
`default_nettype wire

// [test/oprc_role_ctrl_assertions.sv]
// Purpose: port checks of the role control register
// Assumes: outputs trail a write by two edges
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module oprc_role_ctrl_assertions (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic [3:0] bus_be_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic disconnect_then_connect_event_i,
  input wire logic negotiation_active_o,
  input wire logic peripheral_attached_o,
  input wire logic host_attached_o,
  input wire logic bus_reset_req_o
);
  wire logic hit = bus_cs_i && bus_addr_i[15:2] == 14'h00dd;
  wire logic wr_hit = hit && bus_wr_i;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_read_shape: assert property (hit && !bus_wr_i |=> bus_rdata_o[15:11] == 5'h00
    && bus_rdata_o[31:16] == bus_rdata_o[15:0]) else $error("read word malformed");
  a_rdata_idle: assert property (!(hit && !bus_wr_i) |=> bus_rdata_o == 32'h00000000)
    else $error("read data not idle");
  a_role_excl: assert property (peripheral_attached_o |-> !host_attached_o)
    else $error("both controllers attached");
  a_neg_off: assert property (wr_hit && bus_be_i[1] && bus_wdata_i[10]
    |-> ##2 !negotiation_active_o) else $error("negotiation not disabled");
  a_neg_on: assert property (wr_hit && bus_be_i[3] && bus_wdata_i[26] && !bus_wdata_i[10]
    |-> ##2 negotiation_active_o) else $error("negotiation not enabled");
  a_select_set: assert property (wr_hit && bus_be_i[0] && bus_wdata_i[7]
    |-> ##2 peripheral_attached_o) else $error("peripheral not attached");
  a_event_select: assert property ($rose(disconnect_then_connect_event_i)
    |-> ##[2:6] peripheral_attached_o) else $error("event did not select peripheral");
  a_reset_pulse: assert property (bus_reset_req_o |=> !bus_reset_req_o)
    else $error("bus reset request too long");
  c_reset_req: cover property (bus_reset_req_o);
  c_neg_off: cover property (!negotiation_active_o);
  c_role_swap: cover property (host_attached_o ##1 peripheral_attached_o);
endmodule
bind oprc_role_ctrl oprc_role_ctrl_assertions chk (.*);
`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench for the role control register
// Assumes: 40 MHz clock, reset held four cycles
// Notes: table rows first, pin events by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock_i = 1'b0, rst_n_i = 1'b0, bus_cs_i, bus_wr_i, req;
  logic rcon = 1'b0, rdis = 1'b0, evt = 1'b0;
  logic [15:0] bus_addr_i;
  logic [3:0] bus_be_i;
  logic [31:0] bus_wdata_i, bus_rdata_o, rd;
  logic [10:0] pins;
  int failures = 0, checked = 0, cycles = 0;
  // each row: write data, byte enables, control word expected afterwards
  // rows 0 and 1 are the negotiating host and pure host start-up words
  logic [51:0] rows [8] = '{52'h00800018f001e, 52'h00060400f0418, 52'h000007ff307ff,
    52'h07ff0000c0000, 52'h0000016010060, 52'h00600078f0078, 52'h0008000040070,
    52'h007f0200f0200};
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      report_and_stop();
    end
  end
  oprc_sw_model sw (.clock_i(clock_i), .rdata_i(bus_rdata_o), .cs_o(bus_cs_i), .wr_o(bus_wr_i),
    .addr_o(bus_addr_i), .be_o(bus_be_i), .wdata_o(bus_wdata_i));
  oprc_role_ctrl dut (.*, .disconnect_then_connect_event_i(evt), .remote_disconnect_i(rdis),
    .remote_connect_i(rcon), .bus_reset_req_o(req), .negotiation_active_o(pins[10]),
    .peripheral_attached_o(pins[9]), .host_attached_o(pins[8]), .a_connect_allow_o(pins[7]),
    .bus_power_precharge_o(pins[6]), .bus_power_discharge_o(pins[5]),
    .internal_pump_en_o(pins[4]), .external_pump_en_o(pins[3]), .minus_line_pulldown_o(pins[2]),
    .plus_line_pulldown_o(pins[1]), .plus_line_pullup_o(pins[0]));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_is(logic [15:0] r, logic pu);
    sw.xfer(1'b0, 16'h0374, 4'hf, 32'h0, rd);
    check("control word", {r, r}, rd);
    check("pins", {21'h0, ~r[10], r[7], ~r[7], r[8], r[6:5], r[4] & ~r[3], r[4] & r[3],
      r[2:1], r[0] | pu}, {21'h0, pins});
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reg_is(16'h0086, 1'b0);
    foreach (rows[i]) begin
      sw.xfer(1'b1, 16'h0374, rows[i][19:16], rows[i][51:20], rd);
      reg_is(rows[i][15:0], 1'b0);
    end
    sw.xfer(1'b1, 16'h0378, 4'hf, 32'h0000ffff, rd);
    sw.xfer(1'b0, 16'h0378, 4'hf, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    @(posedge clock_i) rcon <= 1'b1;
    repeat (8) @(negedge clock_i) rd[0] = rd[0] | req;
    check("bus reset request", 32'h1, {31'h0, rd[0]});
    @(posedge clock_i) evt <= 1'b1;
    repeat (6) @(posedge clock_i);
    reg_is(16'h0280, 1'b0);
    @(posedge clock_i) rcon <= 1'b0;
    repeat (4) @(posedge clock_i);
    rcon <= 1'b1;
    rd = 32'h0;
    repeat (8) @(negedge clock_i) rd[0] = rd[0] | req;
    check("bus reset request", 32'h0, {31'h0, rd[0]});
    sw.xfer(1'b1, 16'h0374, 4'hf, 32'h02000100, rd);
    @(posedge clock_i) rdis <= 1'b1;
    repeat (6) @(posedge clock_i);
    reg_is(16'h0180, 1'b1);
    @(posedge clock_i) rst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reg_is(16'h0086, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
